//--- hdl/acc_consts.vh
// Notes on behaviour
// - writing control one aborts any conversion and, with software trigger, starts anew unless channel is all ones
// - done flag sets per conversion, or only on true compare when compare enabled
// - done flag is read-only; cleared by control one write or low result read
// - done flag setting with irq enable high raises the interrupt request
// - continuous off: one conversion per software write or hardware trigger
// - continuous on: back-to-back conversions after write or hardware trigger
// - channel codes 0..27 analog inputs, 29 high ref, 30 low ref, 28 reserved
// - channel all ones powers converter off; no extra conversion follows
// - single mode drops to low power by itself after completion
// - active bit sets on start, clears on completion or abort
// - trigger select 0 software write, 1 hardware trigger input
// - compare enable bit turns automatic compare on or off
// - compare direction 0 less than, 1 greater or equal
// - upper result holds bits 9:8 in 10-bit mode, zero in 8-bit mode
// - result registers update unless compare enabled and condition false
// - 10-bit: upper read blocks transfers until lower read; results dropped
// - 8-bit: no interlock between upper and lower result reads
// - changing resolution mode makes upper result contents invalid
// - mode 00 is 8-bit, 10 is 10-bit, 01 and 11 reserved
// - compare uses high compare bits only in 10-bit mode
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
`define ACC_OFS_CS1   3'h0
`define ACC_OFS_CS2   3'h1
`define ACC_OFS_RH    3'h2
`define ACC_OFS_RL    3'h3
`define ACC_OFS_CVH   3'h4
`define ACC_OFS_CVL   3'h5
`define ACC_OFS_CFG   3'h6
`define ACC_B_DONE    7
`define ACC_B_IEN     6
`define ACC_B_CONT    5
`define ACC_B_ACT     7
`define ACC_B_TRG     6
`define ACC_B_CFE     5
`define ACC_B_CGE     4
`define ACC_CH_OFF    5'h1F
`define ACC_MODE_8    2'h0
`define ACC_MODE_10   2'h2
`define ACC_RST_CS1   8'h1F
`define ACC_RST_ZERO  8'h00
`endif

//--- hdl/acc_adc_ctrl.v
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "acc_consts.vh"
module acc_adc_ctrl (
    input  wire        mclk,          // bus clock 25 MHz
    input  wire        arst_n,        // async reset, active low
    input  wire [2:0]  addr,          // register index
    input  wire [7:0]  wdata,         // write data
    input  wire        wr,            // write strobe
    input  wire        rd,            // read strobe
    output reg  [7:0]  rdata,         // read data, cycle after rd
    input  wire        hw_trigger_in, // trigger pulse from counter
    output reg         conv_start,    // pulse: core starts conversion
    output reg  [4:0]  core_channel,  // channel to the core
    output reg         core_power,    // core powered
    output reg         core_ten_bit,  // core in 10-bit mode
    input  wire        core_done,     // pulse: core result ready
    input  wire [9:0]  core_result,   // core result word
    output reg         irq            // conversion complete request
);

    reg [7:0] cs1_r;      // irq en, cont, channel (bit 7 unused)
    reg       done_r;
    reg [7:0] cs2_r;      // trg, cfe, cge (bits 7 and 3:0 unused)
    reg       active_r;
    reg [1:0] cvh_r;
    reg [7:0] cvl_r;
    reg [7:0] cfg_r;
    reg [9:0] res_r;
    reg       lock_r;
    reg       trg_s1_r;
    reg       trg_s2_r;
    reg       trg_d_r;
    reg       armed_r;    // continuous run in progress

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire       wr_cs1   = wr && (addr == `ACC_OFS_CS1);
    wire       rd_rh    = rd && (addr == `ACC_OFS_RH);
    wire       rd_rl    = rd && (addr == `ACC_OFS_RL);
    wire [4:0] chan     = cs1_r[4:0];
    wire       ten_bit  = (cfg_r[3:2] == `ACC_MODE_10);
    wire       hw_mode  = cs2_r[`ACC_B_TRG];
    wire       cont     = cs1_r[`ACC_B_CONT];
    wire       trg_edge = trg_s2_r && !trg_d_r;

    ////////////////////////////////////////////////////////////////////////
    // compare: high bits only take part in 10-bit mode
    wire [9:0] res_m    = ten_bit ? core_result
                                  : {2'h0, core_result[7:0]};
    wire [9:0] cmp_v    = ten_bit ? {cvh_r, cvl_r}
                                  : {2'h0, cvl_r};
    wire       lt       = res_m < cmp_v;
    wire       cmp_ok   = cs2_r[`ACC_B_CGE] ? !lt : lt;
    wire       pass     = !cs2_r[`ACC_B_CFE] || cmp_ok;
    wire       done_ev  = core_done && active_r && !wr_cs1;

    ////////////////////////////////////////////////////////////////////////
    // start requests: a write restarts in software trigger mode unless the channel is off
    wire       wr_off   = (wdata[4:0] == `ACC_CH_OFF);
    wire       sw_start = wr_cs1 && !wr_off && !hw_mode;
    wire       hw_start = hw_mode && trg_edge && chan != `ACC_CH_OFF
                          && !active_r && !wr_cs1;
    // continuous mode chains the next conversion on completion
    wire       chain    = done_ev && cont && chan != `ACC_CH_OFF;

    ////////////////////////////////////////////////////////////////////////
    // trigger synchroniser and edge detect
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            trg_s1_r <= 1'b0;
            trg_s2_r <= 1'b0;
            trg_d_r  <= 1'b0;
        end else begin
            trg_s1_r <= hw_trigger_in;
            trg_s2_r <= trg_s1_r;
            trg_d_r  <= trg_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers written by software
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cs1_r <= `ACC_RST_CS1;
            cs2_r <= `ACC_RST_ZERO;
            cvh_r <= 2'h0;
            cvl_r <= `ACC_RST_ZERO;
            cfg_r <= `ACC_RST_ZERO;
        end else if (wr) begin
            case (addr)
                `ACC_OFS_CS1: cs1_r <= {1'b0, wdata[6:0]};
                // reserved low bits are kept zero regardless
                `ACC_OFS_CS2: cs2_r <= {1'b0, wdata[6:4], 4'h0};
                `ACC_OFS_CVH: cvh_r <= wdata[1:0];
                `ACC_OFS_CVL: cvl_r <= wdata;
                `ACC_OFS_CFG: cfg_r <= wdata;
                default:      cfg_r <= cfg_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencing: active, continuous run, core start
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            active_r   <= 1'b0;
            armed_r    <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            conv_start <= sw_start || hw_start || chain;
            if (wr_cs1) begin
                // abort; restart only for a live channel in sw mode
                active_r <= sw_start;
                armed_r  <= sw_start && wdata[`ACC_B_CONT];
            end else if (hw_start) begin
                active_r <= 1'b1;
                armed_r  <= cont;
            end else if (done_ev) begin
                // single mode stops here and idles the core
                active_r <= chain;
                armed_r  <= chain;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core control outputs
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            core_channel <= `ACC_CH_OFF;
            core_power   <= 1'b0;
            core_ten_bit <= 1'b0;
        end else begin
            core_channel <= chan;
            // all ones isolates the input; idle core sleeps
            core_power   <= chan != `ACC_CH_OFF &&
                            (active_r || armed_r);
            core_ten_bit <= ten_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result transfer and read interlock; a mode change invalidates
    // the held value, so it is simply left stale
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            res_r  <= 10'h000;
            lock_r <= 1'b0;
        end else begin
            if (done_ev && pass && !lock_r)
                res_r <= res_m;
            if (rd_rl || !ten_bit)
                lock_r <= 1'b0;
            else if (rd_rh)
                lock_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // done flag: the set wins over a lower-result read in the same cycle;
    // a control write aborts the conversion so nothing can set then
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            done_r <= 1'b0;
            irq    <= 1'b0;
        end else begin
            if (done_ev && pass)
                done_r <= 1'b1;
            else if (wr_cs1 || rd_rl)
                done_r <= 1'b0;
            irq <= cs1_r[`ACC_B_IEN] &&
                   ((done_ev && pass) || (done_r && !wr_cs1 && !rd_rl));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data in the cycle after the strobe
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `ACC_OFS_CS1: rdata <= {done_r, cs1_r[6:0]};
                `ACC_OFS_CS2: rdata <= {active_r, cs2_r[6:0]};
                `ACC_OFS_RH:  rdata <= {6'h00, res_r[9:8]};
                `ACC_OFS_RL:  rdata <= res_r[7:0];
                `ACC_OFS_CVH: rdata <= {6'h00, cvh_r};
                `ACC_OFS_CVL: rdata <= cvl_r;
                `ACC_OFS_CFG: rdata <= cfg_r;
                default:      rdata <= 8'h00;  // unmapped reads zero
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule // acc_adc_ctrl
`default_nettype wire

//--- sim/acc_adc_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none
module acc_adc_ctrl_chk (
    input wire       mclk,         // bus clock
    input wire       arst_n,       // reset, low
    input wire [2:0] addr,         // register index
    input wire [7:0] wdata,        // write data
    input wire       wr,           // write strobe
    input wire       rd,           // read strobe
    input wire       conv_start,   // start pulse
    input wire       core_power,   // core powered
    input wire       core_ten_bit, // 10-bit mode
    input wire       core_done,    // result pulse
    input wire       irq           // done request
);
    logic trg_r;
    logic cont_r;
    // shadow of trigger and run bits; an off channel never runs on
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            trg_r  <= 1'b0;
            cont_r <= 1'b0;
        end else if (wr) begin
            if (addr == 3'h1) trg_r <= wdata[6];
            if (addr == 3'h0) cont_r <= wdata[5] & ~&wdata[4:0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////
    property p_sw_start; wr && addr == 3'h0 && wdata[4:0] != 5'h1F &&
        !trg_r |=> conv_start; endproperty
    a_sw_start: assert property (p_sw_start) else $error("no start");
    property p_off; wr && addr == 3'h0 && wdata[4:0] == 5'h1F
        |=> !conv_start [*2]; endproperty
    a_off: assert property (p_off) else $error("start while off");
    property p_irq_src; $rose(irq) |-> $past(core_done); endproperty
    a_irq_src: assert property (p_irq_src) else $error("stray irq");
    property p_irq_wclr; wr && addr == 3'h0 |=> !irq; endproperty
    a_irq_wclr: assert property (p_irq_wclr) else $error("irq kept");
    property p_irq_rclr; rd && addr == 3'h3 && !core_done |=> !irq; endproperty
    a_irq_rclr: assert property (p_irq_rclr) else $error("irq held");
    property p_mode; wr && addr == 3'h6
        |-> ##2 core_ten_bit == ($past(wdata[3:2], 2) == 2'h2); endproperty
    a_mode: assert property (p_mode) else $error("bad width");
    property p_pwr; core_done && !wr && !cont_r ##1 !wr [*3]
        |-> !core_power; endproperty
    a_pwr: assert property (p_pwr) else $error("power kept");
    property p_cont; core_done && cont_r && !wr |=> conv_start; endproperty
    a_cont: assert property (p_cont) else $error("no restart");
endmodule // acc_adc_ctrl_chk
bind acc_adc_ctrl acc_adc_ctrl_chk i_chk (.mclk, .arst_n, .addr, .wdata,
    .wr, .rd, .conv_start, .core_power, .core_ten_bit, .core_done, .irq);
`default_nettype wire

//--- sim/acc_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module acc_core_model (
    input  wire       mclk,        // bus clock
    input  wire       arst_n,      // reset, low
    input  wire       conv_start,  // start pulse
    input  wire       core_power,  // core powered
    input  wire [3:0] lat,         // cycles to result
    input  wire [9:0] val,         // result to return
    output reg        core_done,   // result pulse
    output reg  [9:0] core_result  // result word
);
    reg [3:0] cnt_r;
    // countdown per start; power loss abandons it, idle result toggles
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r       <= 4'h0;
            core_done   <= 1'b0;
            core_result <= 10'h155;
        end else begin
            core_done   <= 1'b0;
            core_result <= ~core_result;
            if (conv_start) begin
                cnt_r <= lat;
            end else if (!core_power) begin
                cnt_r <= 4'h0;
            end else if (cnt_r != 4'h0) begin
                cnt_r       <= cnt_r - 4'h1;
                core_done   <= (cnt_r == 4'h1);
                core_result <= (cnt_r == 4'h1) ? val : ~core_result;
            end
        end
    end
endmodule // acc_core_model
`default_nettype wire

//--- sim/acc_adc_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module acc_adc_ctrl_tb;
    logic       mclk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic       hw_trigger_in = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [3:0] lat = 4'h8;
    logic [9:0] val = 10'h000, core_result;
    logic [4:0] core_channel;
    logic       conv_start, core_power, core_ten_bit, core_done, irq;
    int         errors = 0, checked = 0, n;
    acc_adc_ctrl i_dut (.mclk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
        .hw_trigger_in, .conv_start, .core_channel, .core_power,
        .core_ten_bit, .core_done, .core_result, .irq);
    acc_core_model i_core (.mclk, .arst_n, .conv_start, .core_power, .lat,
        .val, .core_done, .core_result);
    initial forever #20 mclk = ~mclk;
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a, input logic [7:0] e, string nm);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        chk(nm, rdata, e);
    endtask
    // bounded wait for a core result; a hang ends the run
    task automatic wdone;
        for (n = 0; n < 40 && core_done !== 1'b1; n++) @(posedge mclk);
        if (core_done !== 1'b1) begin
            errors++;
            report_and_stop;
        end
    endtask
    task automatic quiet(input int c);
        n = 0;
        repeat (c) begin
            @(posedge mclk);
            n += conv_start;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_single;
        wreg(3'h7, 8'hFF);
        rreg(3'h7, 8'h00, "unmapped");
        wreg(3'h6, 8'h08);
        wreg(3'h1, 8'h00);
        val <= 10'h2A5;
        wreg(3'h0, 8'h45);
        rreg(3'h1, 8'h80, "active");
        chk("channel", {3'h0, core_channel}, 8'h05);
        wdone;
        rreg(3'h0, 8'hC5, "done");
        chk("irq", {7'h00, irq}, 8'h01);
        rreg(3'h2, 8'h02, "high");
        rreg(3'h3, 8'hA5, "low");
        rreg(3'h0, 8'h45, "cleared");
        rreg(3'h1, 8'h00, "idle");
        $display("single conversion test ends");
    endtask
    task automatic t_cmp;
        wreg(3'h6, 8'h00);
        wreg(3'h4, 8'h03);
        wreg(3'h5, 8'h40);
        wreg(3'h1, 8'h20);
        rreg(3'h4, 8'h03, "cmp high");
        rreg(3'h6, 8'h00, "mode 8");
        val <= 10'h330;
        wreg(3'h0, 8'h05);
        wdone;
        rreg(3'h0, 8'h85, "lt hit");
        rreg(3'h2, 8'h00, "high 8");
        rreg(3'h3, 8'h30, "low 8");
        val <= 10'h050;
        wreg(3'h0, 8'h05);
        wdone;
        rreg(3'h0, 8'h05, "lt miss");
        rreg(3'h3, 8'h30, "kept");
        rreg(3'h2, 8'h00, "high read");
        wreg(3'h1, 8'h30);
        wreg(3'h0, 8'h05);
        wdone;
        rreg(3'h3, 8'h50, "ge hit");
        $display("compare test ends");
    endtask
    task automatic t_lock;
        wreg(3'h6, 8'h08);
        rreg(3'h6, 8'h08, "mode 10");
        wreg(3'h1, 8'h00);
        val <= 10'h1C3;
        wreg(3'h0, 8'h25);
        wdone;
        rreg(3'h2, 8'h01, "lock high");
        val <= 10'h0FF;
        wdone;
        rreg(3'h3, 8'hC3, "locked low");
        wdone;
        rreg(3'h3, 8'hFF, "fresh low");
        wreg(3'h0, 8'h1F);
        quiet(20);
        chk("stop starts", n[7:0], 8'h00);
        $display("interlock test ends");
    endtask
    task automatic t_hw;
        wreg(3'h1, 8'h40);
        wreg(3'h0, 8'h45);
        quiet(10);
        chk("hw idle", n[7:0], 8'h00);
        lat <= 4'h3;
        hw_trigger_in <= 1'b1;
        wdone;
        rreg(3'h0, 8'hC5, "hw done");
        quiet(30);
        chk("one shot", n[7:0], 8'h00);
        rreg(3'h3, 8'hFF, "hw low");
        hw_trigger_in <= 1'b0;
        $display("hardware trigger test ends");
    endtask
    task automatic report_and_stop;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        t_single;
        t_cmp;
        t_lock;
        t_hw;
        report_and_stop;
    end
endmodule // acc_adc_ctrl_tb
`default_nettype wire
